// ===== apm_pkg.sv
// apm_pkg: shared constants and types of the amplifier protection block
// assumes a 100 MHz system clock; supply and output voltages arrive as millivolt codes
package apm_pkg;
	// clock
	localparam int CLK_HZ           = 100000000;
	// timing, in their own units and in cycles
	localparam int POWERUP_MS       = 40;
	localparam int POWERUP_CYCLES   = POWERUP_MS * (CLK_HZ / 1000);
	localparam int DC_QUAL_MS       = 640;
	localparam int DC_QUAL_CYCLES   = DC_QUAL_MS * (CLK_HZ / 1000);
	// supply window in millivolts (4.5 V .. 27 V)
	localparam logic [15:0] SUPPLY_MIN_MV = 16'h1194;
	localparam logic [15:0] SUPPLY_MAX_MV = 16'h6978;
	// die temperature trip in degrees C (150)
	localparam logic signed [9:0] TEMP_TRIP_C = 10'h096;
	// dc threshold is 3/10 of the supply
	localparam logic [17:0] DC_THR_MUL = 18'h0_0003;
	localparam logic [17:0] DC_THR_DIV = 18'h0_000A;
	// modulation carrier midpoint (50 % duty)
	localparam logic [8:0] DUTY_HALF = 9'h080;
	// fault latch bit positions
	localparam int FLT_OC   = 0;
	localparam int FLT_TEMP = 1;
	localparam int FLT_DC   = 2;
	localparam logic [2:0] FLT_NONE = 3'h0;
	// reset values of the output flops
	localparam logic RST_FAULT_N  = 1'b1;
	localparam logic RST_DRIVE_EN_N = 1'b1;
	localparam logic RST_LOW_CUR  = 1'b1;

	typedef enum logic {modBd, modLowIdle} apm_mod_t;
	typedef enum logic [1:0] {stPowerUp, stShutdown, stActive} apm_state_t;
endpackage

// ===== apm_chan_if.sv
// apm_chan_if: per-channel signals between the controller, dc detector and modulator
// assumes one instance per audio channel, all in the clk domain
`timescale 1ns/1ps
interface apm_chan_if;
	logic signed [15:0] sample;
	logic        [15:0] threshold;
	logic               detEnable;
	logic               dcFault;
	logic signed [7:0]  level;
	apm_pkg::apm_mod_t  mode;
	logic               run;
	logic               pwmP;
	logic               pwmN;

	modport ctrl (output sample, threshold, detEnable, level, mode, run,
		input dcFault, pwmP, pwmN);
	modport detect (input sample, threshold, detEnable, output dcFault);
	modport modulate (input level, mode, run, output pwmP, pwmN);
endinterface // apm_chan_if

// ===== apm_dc_detect.sv
// apm_dc_detect: flags a channel whose differential output sits beyond threshold too long
// assumes sample is the signed differential output in millivolts, one per clock
`timescale 1ns/1ps
module apm_dc_detect #(
	parameter int QUAL_CYCLES = apm_pkg::DC_QUAL_CYCLES
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic reset,
	// channel link
	apm_chan_if.detect ch
);
	logic [31:0] count;
	logic        lastNeg;
	logic        fault;
	logic [31:0] next_count;
	logic        next_lastNeg;
	logic        next_fault;
	logic [16:0] magnitude;
	logic        over;

	// no high-pass here: a sub-2 Hz swing looks like dc to this detector
	always_comb begin
		magnitude = ch.sample[15] ? 17'(-$signed({ch.sample[15], ch.sample}))
			: {1'b0, ch.sample};
		over = magnitude >= {1'b0, ch.threshold};
		next_count = count;
		next_lastNeg = lastNeg;
		next_fault = fault;
		if (!ch.detEnable) begin
			next_count = '0;
			next_fault = 1'b0;
		end else if (!fault) begin
			if (!over) begin
				next_count = '0;
			end else if (count != '0 && ch.sample[15] != lastNeg) begin
				next_count = 32'h0000_0001; // polarity flip restarts
			end else if (count >= 32'(QUAL_CYCLES)) begin
				next_fault = 1'b1;
			end else begin
				next_count = count + 32'h0000_0001;
			end
			next_lastNeg = ch.sample[15];
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			count <= '0;
			lastNeg <= 1'b0;
			fault <= 1'b0;
		end else begin
			count <= next_count;
			lastNeg <= next_lastNeg;
			fault <= next_fault;
		end
	end

	assign ch.dcFault = fault;

	chk_dc_after_qual: assert property (@(posedge clk) disable iff (reset)
		$rose(fault) |-> $past(count) == 32'(QUAL_CYCLES) && $past(over))
		else $error("dc fault raised before the qualification time");
	chk_dc_short_drop: assert property (@(posedge clk) disable iff (reset)
		(ch.detEnable && !fault && !over) |=> count == '0)
		else $error("dc counter kept running below threshold");
endmodule // apm_dc_detect

// ===== apm_bd_modulator.sv
// apm_bd_modulator: per-channel pwm for the positive and negative outputs
// assumes level is a signed audio sample; outputs are idle low while run is low
`timescale 1ns/1ps
module apm_bd_modulator (
	// clock and reset
	input  wire logic clk,
	input  wire logic reset,
	// channel link
	apm_chan_if.modulate ch
);
	logic [7:0] carrier;
	logic       pwmP;
	logic       pwmN;
	logic [7:0] next_carrier;
	logic       next_pwmP;
	logic       next_pwmN;
	logic [8:0] posDuty;
	logic [8:0] negDuty;
	logic [7:0] magnitude;

	always_comb begin
		next_carrier = carrier + 8'h01;
		magnitude = ch.level[7] ? 8'(-ch.level) : 8'(ch.level);
		if (ch.mode == apm_pkg::modBd) begin
			// equal duties at zero input, so both legs switch in phase
			posDuty = apm_pkg::DUTY_HALF + {ch.level[7], ch.level};
			negDuty = apm_pkg::DUTY_HALF - {ch.level[7], ch.level};
		end else begin
			// low idle-loss: only the active leg switches, idle draws no ripple
			posDuty = ch.level[7] ? 9'h000 : {magnitude, 1'b0};
			negDuty = ch.level[7] ? {magnitude, 1'b0} : 9'h000;
		end
		next_pwmP = ch.run && ({1'b0, carrier} < posDuty);
		next_pwmN = ch.run && ({1'b0, carrier} < negDuty);
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			carrier <= '0;
			pwmP <= 1'b0;
			pwmN <= 1'b0;
		end else begin
			carrier <= next_carrier;
			pwmP <= next_pwmP;
			pwmN <= next_pwmN;
		end
	end

	assign ch.pwmP = pwmP;
	assign ch.pwmN = pwmN;

	chk_bd_in_phase: assert property (@(posedge clk) disable iff (reset)
		(ch.mode == apm_pkg::modBd && ch.level == 8'sh00) |=> pwmP == pwmN)
		else $error("bd legs not in phase at zero input");
	chk_bd_pos_duty: assert property (@(posedge clk) disable iff (reset)
		(ch.run && ch.mode == apm_pkg::modBd && ch.level > 8'sh00 && carrier == 8'h80)
		|=> pwmP && !pwmN)
		else $error("bd duty wrong for positive output");
	chk_bd_neg_duty: assert property (@(posedge clk) disable iff (reset)
		(ch.run && ch.mode == apm_pkg::modBd && ch.level < 8'sh00 && carrier == 8'h80)
		|=> !pwmP && pwmN)
		else $error("bd duty wrong for negative output");
endmodule // apm_bd_modulator

// ===== apm_fault_ctrl.sv
// apm_fault_ctrl: protection, fault reporting and output control of a stereo class-d stage
// assumes analog monitors arrive as synchronous digital codes: supply in millivolts,
// die temperature in degrees C, differential outputs in millivolts; overcurrent is a
// comparator level.
//
// How it works
// - output overcurrent latches a fault: fault pin low, outputs high impedance
// - die above 150 C shuts down, latches a fault, fault pin low; not sensed until power-up ends
// - dc fault drives fault pin low, outputs high impedance, stays latched
// - dc fault only after same-polarity excursion beyond threshold over 640 ms
// - dc threshold is 0.3 times the power-stage supply
// - slow swings below 2 Hz count as dc for detection
// - taking shutdown low then high clears latched faults
// - shutdown low mutes outputs and enters low-current state
// - a 40 ms power-up sequence precedes normal operation
// - two modulation options: bridge differential and low idle-loss
// - bridge differential: legs switch rail to rail, in phase at zero input
// - bridge differential: positive output means positive leg above 50 % duty
`timescale 1ns/1ps
module apm_fault_ctrl #(
	parameter int POWERUP_CYCLES = apm_pkg::POWERUP_CYCLES,
	parameter int DC_QUAL_CYCLES = apm_pkg::DC_QUAL_CYCLES
) (
	// clock and reset
	input  wire logic                    clk,
	input  wire logic                    reset,
	// controller pins
	input  wire logic                    shutdown_in_n,
	output logic                         fault_out_n,
	// analog monitors
	input  wire logic                    overcurrentDetect,
	input  wire logic signed [9:0]       dieTempC,
	input  wire logic [15:0]             power_stage_supply,
	input  wire logic [1:0][15:0]        diffOutMilliVolt,
	// audio and mode
	input  wire logic [1:0][7:0]         audioLevel,
	input  wire logic                    lowIdleMode,
	// power stage
	output logic [1:0]                   channel_positive_output,
	output logic [1:0]                   channel_negative_output,
	output logic                         outputDriveEn_n,
	output logic                         lowCurrentState
);
	apm_pkg::apm_state_t state;
	apm_pkg::apm_state_t next_state;
	logic [31:0]         puCount;
	logic [31:0]         next_puCount;
	logic [2:0]          faultLatch;
	logic [2:0]          next_faultLatch;
	logic                faultOutN;
	logic                next_faultOutN;
	logic                driveEnN;
	logic                next_driveEnN;
	logic                lowCur;
	logic                next_lowCur;
	logic                running;
	logic                next_running;
	logic [2:0]          faultSet;
	logic                supplyOk;
	logic                dcAny;
	logic [17:0]         thrWide;
	logic [15:0]         dcThreshold;
	logic [1:0]          chDcFault;

	apm_chan_if chan [2] ();

	// dc threshold tracks the supply; integer divide floors by under a millivolt
	always_comb begin
		thrWide = ({2'b00, power_stage_supply} * apm_pkg::DC_THR_MUL) / apm_pkg::DC_THR_DIV;
		dcThreshold = thrWide[15:0];
	end

	for (genvar i = 0; i < 2; i++) begin : g_chan
		assign chan[i].sample = $signed(diffOutMilliVolt[i]);
		assign chan[i].threshold = dcThreshold;
		// detection only while amplifying in range, so shutdown starts it afresh
		assign chan[i].detEnable = running;
		assign chan[i].level = $signed(audioLevel[i]);
		assign chan[i].mode = lowIdleMode ? apm_pkg::modLowIdle : apm_pkg::modBd;
		assign chan[i].run = running;
		assign chDcFault[i] = chan[i].dcFault;
		assign channel_positive_output[i] = chan[i].pwmP;
		assign channel_negative_output[i] = chan[i].pwmN;

		apm_dc_detect #(
			.QUAL_CYCLES (DC_QUAL_CYCLES)
		) u_dc (
			.clk   (clk),
			.reset (reset),
			.ch    (chan[i])
		);

		apm_bd_modulator u_mod (
			.clk   (clk),
			.reset (reset),
			.ch    (chan[i])
		);
	end

	// fault sources and supply window
	always_comb begin
		supplyOk = (power_stage_supply >= apm_pkg::SUPPLY_MIN_MV)
			&& (power_stage_supply <= apm_pkg::SUPPLY_MAX_MV);
		dcAny = |chDcFault;
		faultSet = apm_pkg::FLT_NONE;
		// a short is only seen while the bridge drives
		faultSet[apm_pkg::FLT_OC] = overcurrentDetect && running;
		faultSet[apm_pkg::FLT_TEMP] = (dieTempC > apm_pkg::TEMP_TRIP_C)
			&& (state != apm_pkg::stPowerUp);
		faultSet[apm_pkg::FLT_DC] = dcAny;
	end

	// sequencing: power-up wait, then follow the shutdown pin
	always_comb begin
		next_state = state;
		next_puCount = puCount;
		unique case (state)
			apm_pkg::stPowerUp: begin
				if (puCount >= 32'(POWERUP_CYCLES - 1)) begin
					next_state = shutdown_in_n ? apm_pkg::stActive : apm_pkg::stShutdown;
				end else begin
					next_puCount = puCount + 32'h0000_0001;
				end
			end
			apm_pkg::stShutdown: begin
				if (shutdown_in_n) begin
					next_state = apm_pkg::stActive;
				end
			end
			apm_pkg::stActive: begin
				if (!shutdown_in_n) begin
					next_state = apm_pkg::stShutdown;
				end
			end
			default: begin
				next_state = apm_pkg::stPowerUp;
			end
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state <= apm_pkg::stPowerUp;
			puCount <= '0;
		end else begin
			state <= next_state;
			puCount <= next_puCount;
		end
	end

	// fault latch: cleared while shutdown is low, but a new event still wins
	always_comb begin
		if (!shutdown_in_n) begin
			next_faultLatch = faultSet;
		end else begin
			next_faultLatch = faultLatch | faultSet;
		end
		// tying fault to shutdown loops here and clears itself unless the die is still above the trip temperature
		next_faultOutN = (next_faultLatch == apm_pkg::FLT_NONE);
		// undervoltage and overvoltage only gate the bridge, never the fault pin
		next_running = (next_state == apm_pkg::stActive)
			&& (next_faultLatch == apm_pkg::FLT_NONE) && supplyOk;
		next_driveEnN = !next_running;
		next_lowCur = (next_state != apm_pkg::stActive);
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			faultLatch <= apm_pkg::FLT_NONE;
			faultOutN <= apm_pkg::RST_FAULT_N;
			driveEnN <= apm_pkg::RST_DRIVE_EN_N;
			lowCur <= apm_pkg::RST_LOW_CUR;
			running <= 1'b0;
		end else begin
			faultLatch <= next_faultLatch;
			faultOutN <= next_faultOutN;
			driveEnN <= next_driveEnN;
			lowCur <= next_lowCur;
			running <= next_running;
		end
	end

	assign fault_out_n = faultOutN;
	assign outputDriveEn_n = driveEnN;
	assign lowCurrentState = lowCur;

	// power-up helper: cycles spent since reset, saturating
	logic [31:0] sinceReset;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sinceReset <= '0;
		end else if (sinceReset != 32'hFFFF_FFFF) begin
			sinceReset <= sinceReset + 32'h0000_0001;
		end
	end

	sequence s_short_seen;
		running && overcurrentDetect;
	endsequence

	sequence s_fault_held;
		!fault_out_n && outputDriveEn_n;
	endsequence

	chk_oc_latch: assert property (@(posedge clk) disable iff (reset)
		s_short_seen ##1 shutdown_in_n [*2] |-> s_fault_held)
		else $error("overcurrent did not latch a fault");
	chk_temp_trip: assert property (@(posedge clk) disable iff (reset)
		(dieTempC > apm_pkg::TEMP_TRIP_C && state != apm_pkg::stPowerUp)
		|=> s_fault_held)
		else $error("over temperature did not shut down");
	chk_dc_report: assert property (@(posedge clk) disable iff (reset)
		$rose(dcAny) |=> s_fault_held ##1 (!shutdown_in_n || (!fault_out_n && outputDriveEn_n)))
		else $error("dc fault not reported or not held");
	chk_supply_quiet: assert property (@(posedge clk) disable iff (reset)
		(!supplyOk && faultSet == apm_pkg::FLT_NONE && faultLatch == apm_pkg::FLT_NONE)
		|=> fault_out_n && outputDriveEn_n)
		else $error("supply window fault misreported");
	chk_supply_resume: assert property (@(posedge clk) disable iff (reset)
		(state == apm_pkg::stActive && shutdown_in_n && supplyOk
			&& faultSet == apm_pkg::FLT_NONE && faultLatch == apm_pkg::FLT_NONE)
		|=> !outputDriveEn_n)
		else $error("outputs did not resume with supply in range");
	chk_latch_clear: assert property (@(posedge clk) disable iff (reset)
		(!shutdown_in_n && faultSet == apm_pkg::FLT_NONE) |=> fault_out_n)
		else $error("shutdown low did not clear the fault latch");
	chk_sd_mute: assert property (@(posedge clk) disable iff (reset)
		// the legs still carry the last carrier cycle one edge after the bridge stops
		!shutdown_in_n |=> outputDriveEn_n && lowCurrentState
			##1 (channel_positive_output == 2'b00 && channel_negative_output == 2'b00))
		else $error("shutdown did not mute the outputs");
	chk_powerup_wait: assert property (@(posedge clk) disable iff (reset)
		(sinceReset < 32'(POWERUP_CYCLES)) |-> outputDriveEn_n && state == apm_pkg::stPowerUp)
		else $error("bridge enabled before power-up completed");
	chk_powerup_end: assert property (@(posedge clk) disable iff (reset)
		(sinceReset == 32'(POWERUP_CYCLES)) |-> state != apm_pkg::stPowerUp)
		else $error("power-up sequence overran");
endmodule // apm_fault_ctrl

// ===== apm_sys_ctrl_model.sv
// apm_sys_ctrl_model: behavioural system controller on the shutdown and fault pins
// assumes the bench changes its commands just after falling clock edges
`timescale 1ns/1ps
module apm_sys_ctrl_model (
	// commands from the bench
	input  wire logic hostShutdown_n,
	input  wire logic autoRecover,
	// device pins
	input  wire logic fault_out_n,
	output logic      shutdown_in_n
);
	// bench starts with hostShutdown_n low so the pin stays low at power-up
	// the recovery tie is a plain wire, so the pin follows the fault pin at once
	assign shutdown_in_n = autoRecover ? (hostShutdown_n & fault_out_n) : hostShutdown_n;
endmodule // apm_sys_ctrl_model

// ===== apm_fault_ctrl_tb.sv
// apm_fault_ctrl_tb: self-checking bench of the amplifier protection block
// assumes shortened counts: 20 power-up cycles and 8 dc qualify cycles
`timescale 1ns/1ps
module apm_fault_ctrl_tb;
	localparam int PU = 20;
	localparam int DCQ = 8;
	logic                   clk;
	logic                   reset;
	logic                   hostSd_n;
	logic                   autoRec;
	logic                   sdPin_n;
	logic                   fault_out_n;
	logic                   ocDet;
	logic signed [9:0]      tempC;
	logic [15:0]            supply;
	logic [1:0][15:0]       diffMv;
	logic [1:0][7:0]        level;
	logic                   lowIdle;
	logic [1:0]             posOut;
	logic [1:0]             negOut;
	logic                   drvEn_n;
	logic                   lowCur;
	int                     fail_count;
	int                     n_compared;
	int                     cycles;

	apm_fault_ctrl #(.POWERUP_CYCLES(PU), .DC_QUAL_CYCLES(DCQ)) dut (
		.clk(clk), .reset(reset), .shutdown_in_n(sdPin_n), .fault_out_n(fault_out_n),
		.overcurrentDetect(ocDet), .dieTempC(tempC), .power_stage_supply(supply),
		.diffOutMilliVolt(diffMv), .audioLevel(level), .lowIdleMode(lowIdle),
		.channel_positive_output(posOut), .channel_negative_output(negOut),
		.outputDriveEn_n(drvEn_n), .lowCurrentState(lowCur));
	apm_sys_ctrl_model partner (.hostShutdown_n(hostSd_n), .autoRecover(autoRec),
		.fault_out_n(fault_out_n), .shutdown_in_n(sdPin_n));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic give_verdict();
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// hang guard: the full sequence needs well under 5000 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			give_verdict();
		end
	end

	task automatic check_bit(input string name, input logic exp, input logic got);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s expected %b seen %b", name, exp, got);
		end
	endtask

	task automatic check_num(input string name, input int exp, input int got);
		n_compared++;
		if (got != exp) begin
			fail_count++;
			$display("BAD %s expected %0d seen %0d", name, exp, got);
		end
	endtask

	function automatic logic sig(input int sel);
		return (sel == 0) ? fault_out_n : (sel == 1) ? drvEn_n : lowCur;
	endfunction

	// bounded wait on a design output, then compare
	task automatic wait_sig(input string name, input int sel, input logic exp, input int lim);
		int i;
		i = 0;
		while (sig(sel) !== exp && i < lim) begin
			@(negedge clk);
			i++;
		end
		check_bit(name, exp, sig(sel));
	endtask

	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic do_reset(input logic sdLevel);
		reset = 1'b1;
		hostSd_n = sdLevel;
		idle(6);
		check_bit("fault in reset", 1'b1, fault_out_n);
		check_bit("drive in reset", 1'b1, drvEn_n);
		check_bit("lowcur in reset", 1'b1, lowCur);
		reset = 1'b0;
	endtask

	task automatic clear_latch();
		hostSd_n = 1'b0;
		idle(3);
		check_bit("fault after clear", 1'b1, fault_out_n);
		check_bit("lowcur in shutdown", 1'b1, lowCur);
		check_bit("pwm muted", 1'b1, posOut === 2'b00 && negOut === 2'b00);
		hostSd_n = 1'b1;
		wait_sig("drive after clear", 1, 1'b0, 4);
	endtask

	task automatic test_powerup();
		do_reset(1'b0);
		idle(PU + 10);
		check_bit("lowcur held by shutdown", 1'b1, lowCur);
		hostSd_n = 1'b1;
		wait_sig("active after shutdown", 2, 1'b0, 3);
		do_reset(1'b1);
		idle(PU - 2);
		check_bit("still powering up", 1'b1, lowCur);
		check_bit("drive off in power-up", 1'b1, drvEn_n);
		wait_sig("active after power-up", 2, 1'b0, 4);
		wait_sig("drive after power-up", 1, 1'b0, 2);
	endtask

	task automatic test_overcurrent();
		ocDet = 1'b1;
		idle(1);
		ocDet = 1'b0;
		wait_sig("fault on short", 0, 1'b0, 3);
		check_bit("hi-z on short", 1'b1, drvEn_n);
		idle(5);
		check_bit("short latched", 1'b0, fault_out_n);
		clear_latch();
		autoRec = 1'b1;
		ocDet = 1'b1;
		idle(1);
		ocDet = 1'b0;
		wait_sig("auto fault", 0, 1'b0, 3);
		wait_sig("auto release", 0, 1'b1, 4);
		wait_sig("auto resume", 1, 1'b0, 6);
		autoRec = 1'b0;
	endtask

	task automatic test_thermal();
		tempC = 10'sd150;
		idle(10);
		check_bit("no trip at 150", 1'b1, fault_out_n);
		tempC = 10'sd151;
		wait_sig("trip above 150", 0, 1'b0, 3);
		check_bit("hi-z on trip", 1'b1, drvEn_n);
		tempC = 10'sd25;
		idle(4);
		check_bit("trip latched", 1'b0, fault_out_n);
		clear_latch();
	endtask

	task automatic test_supply(input int bad);
		supply = 16'(bad);
		wait_sig("drive off out of range", 1, 1'b1, 3);
		check_bit("no fault on supply", 1'b1, fault_out_n);
		supply = 16'd12000;
		wait_sig("drive back in range", 1, 1'b0, 3);
	endtask

	task automatic dc_case(input int sup, input int thr, input int ch, input bit neg);
		int s;
		s = neg ? -1 : 1;
		supply = 16'(sup);
		wait_sig("drive at supply", 1, 1'b0, 3);
		diffMv[ch] = 16'(s * (thr - 1));
		idle(30);
		check_bit("below threshold", 1'b1, fault_out_n);
		repeat (5) begin
			diffMv[ch] = 16'(thr);
			idle(6);
			diffMv[ch] = 16'(-thr);
			idle(6);
		end
		check_bit("polarity flips", 1'b1, fault_out_n);
		// a gap below threshold, else a negative run would extend the last flip's count
		diffMv[ch] = 16'h0000;
		idle(1);
		diffMv[ch] = 16'(s * thr);
		idle(DCQ);
		check_bit("too short for dc", 1'b1, fault_out_n);
		wait_sig("dc fault", 0, 1'b0, 6);
		check_bit("hi-z on dc", 1'b1, drvEn_n);
		diffMv[ch] = 16'h0000;
		idle(3);
		check_bit("dc latched", 1'b0, fault_out_n);
		clear_latch();
	endtask

	task automatic duty(input logic mode, input int lv, input int expP, input int expN);
		int nP;
		int nN;
		int apart;
		int unk;
		nP = 0;
		nN = 0;
		apart = 0;
		unk = 0;
		lowIdle = mode;
		level = {8'(lv), 8'(lv)};
		idle(4);
		repeat (256) begin
			@(negedge clk);
			nP += int'(posOut[0]) + int'(posOut[1]);
			nN += int'(negOut[0]) + int'(negOut[1]);
			apart += int'(posOut !== negOut);
			// an unknown leg would count as zero above and slip through
			unk += int'($isunknown({posOut, negOut}));
		end
		check_num("pwm known", 0, unk);
		check_num("positive duty", 2 * expP, nP);
		check_num("negative duty", 2 * expN, nN);
		if (lv == 0 && mode == 1'b0)
			check_num("legs in phase", 0, apart);
	endtask

	initial begin
		fail_count = 0;
		n_compared = 0;
		cycles = 0;
		reset = 1'b1;
		hostSd_n = 1'b0;
		autoRec = 1'b0;
		ocDet = 1'b0;
		tempC = 10'sd25;
		supply = 16'd12000;
		diffMv = '0;
		level = '0;
		lowIdle = 1'b0;
		test_powerup();
		test_overcurrent();
		test_thermal();
		test_supply(4499);
		test_supply(27001);
		supply = 16'd27000;
		idle(3);
		check_bit("27 V in range", 1'b0, drvEn_n);
		dc_case(4500, 1350, 0, 1'b0);
		dc_case(6000, 1800, 1, 1'b1);
		dc_case(12000, 3600, 0, 1'b1);
		dc_case(18000, 5400, 1, 1'b0);
		duty(1'b0, 0, 128, 128);
		duty(1'b0, 64, 192, 64);
		duty(1'b0, -64, 64, 192);
		duty(1'b1, 64, 128, 0);
		duty(1'b1, -64, 0, 128);
		clear_latch();
		give_verdict();
	end
endmodule // apm_fault_ctrl_tb
